// ==== inc/rtk_cfg.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * timekeeping block. Assumes it is included by its bare name.
 */
`ifndef RTK_CFG_SVH
`define RTK_CFG_SVH
`define RTK_REG_CTRL 8'h00
`define RTK_REG_SEC 8'h02
`define RTK_REG_MIN 8'h03
`define RTK_REG_HOUR 8'h04
`define RTK_REG_WDAY 8'h05
`define RTK_REG_DATE 8'h06
`define RTK_REG_MON 8'h07
`define RTK_REG_YEAR 8'h08
`define RTK_REG_WDRF 8'h09
`define RTK_CTRL_RD_BIT 0
`define RTK_CTRL_WR_BIT 1
`define RTK_CTRL_CF_BIT 6
`define RTK_WDRF_WTO_BIT 7
`define RTK_WDRF_LOWSUP_BIT 6
`define RTK_WDRF_LB_BIT 5
`define RTK_WDRF_KEY 4'hA
`define RTK_SLAVE_ID 4'hD
`define RTK_MASK_SEC 8'h7F
`define RTK_MASK_MIN 8'h7F
`define RTK_MASK_HOUR 8'h3F
`define RTK_MASK_WDAY 8'h07
`define RTK_MASK_DATE 8'h3F
`define RTK_MASK_MON 8'h1F
`define RTK_MASK_YEAR 8'hFF
`define RTK_RST_ZERO 8'h00
`define RTK_RST_ONE 8'h01
`define RTK_MAX_SEC 8'h59
`define RTK_MAX_HOUR 8'h23
`define RTK_MAX_WDAY 8'h07
`define RTK_MAX_MON 8'h12
`define RTK_MAX_YEAR 8'h99
`define RTK_TICK_PERIOD_NS 1000000000
`define RTK_CLK_PERIOD_NS 25
`endif

// ==== inc/rtk_pkg.sv ====
/*
 * Types shared by the timekeeping block.
 * Assumes rtk_cfg.svh supplies the numeric constants.
 */
package rtk_pkg;
    typedef logic [7:0] rtk_byte_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DEV = 5'b00010,
        ST_PTR = 5'b00100,
        ST_WR = 5'b01000,
        ST_RD = 5'b10000
    } rtk_state_e;
endpackage : rtk_pkg

// ==== logic/rtk_core.sv ====
/*
 * Running BCD time counters, stepped by a one-second enable.
 * Assumes the parent gives a one-cycle tick and a one-cycle load pulse.
 */
`timescale 1ns/1ps
`include "rtk_cfg.svh"
module rtk_core
    import rtk_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire logic load,
    input wire rtk_byte_t ld_sec,
    input wire rtk_byte_t ld_min,
    input wire rtk_byte_t ld_hour,
    input wire rtk_byte_t ld_wday,
    input wire rtk_byte_t ld_date,
    input wire rtk_byte_t ld_mon,
    input wire rtk_byte_t ld_year,
    output rtk_byte_t sec,
    output rtk_byte_t min,
    output rtk_byte_t hour,
    output rtk_byte_t wday,
    output rtk_byte_t date,
    output rtk_byte_t mon,
    output rtk_byte_t year,
    output logic century
);
    // Returns {wrap, next} for a BCD counter running from mn to mx.
    function automatic logic [8:0] bcd_step(input rtk_byte_t v, input rtk_byte_t mx,
        input rtk_byte_t mn);
        if (v >= mx)
            bcd_step = {1'b1, mn};
        else if (v[3:0] >= 4'h9)
            bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
        else
            bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_step

    // Last date of a month; leap years are multiples of four within the century.
    function automatic rtk_byte_t last_date(input rtk_byte_t m, input rtk_byte_t y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == 8'h02)
            last_date = leap ? 8'h29 : 8'h28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            last_date = 8'h30;
        else
            last_date = 8'h31;
    endfunction : last_date

    logic [8:0] s_n, m_n, h_n, w_n, d_n, mo_n, y_n;
    logic en_min, en_hour, en_day, en_mon, en_year;

    // Carry chain; the weekday ring steps with the date but is not tied to it.
    assign s_n = bcd_step(sec, `RTK_MAX_SEC, `RTK_RST_ZERO);
    assign m_n = bcd_step(min, `RTK_MAX_SEC, `RTK_RST_ZERO);
    assign h_n = bcd_step(hour, `RTK_MAX_HOUR, `RTK_RST_ZERO);
    assign w_n = bcd_step(wday, `RTK_MAX_WDAY, `RTK_RST_ONE);
    assign d_n = bcd_step(date, last_date(mon, year), `RTK_RST_ONE);
    assign mo_n = bcd_step(mon, `RTK_MAX_MON, `RTK_RST_ONE);
    assign y_n = bcd_step(year, `RTK_MAX_YEAR, `RTK_RST_ZERO);
    assign en_min = tick & s_n[8];
    assign en_hour = en_min & m_n[8];
    assign en_day = en_hour & h_n[8];
    assign en_mon = en_day & d_n[8];
    assign en_year = en_mon & mo_n[8];

    // A load from the user registers wins over a tick in the same cycle.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sec <= `RTK_RST_ZERO;
            min <= `RTK_RST_ZERO;
            hour <= `RTK_RST_ZERO;
            wday <= `RTK_RST_ONE;
            date <= `RTK_RST_ONE;
            mon <= `RTK_RST_ONE;
            year <= `RTK_RST_ZERO;
        end
        else if (load)
        begin
            sec <= ld_sec;
            min <= ld_min;
            hour <= ld_hour;
            wday <= ld_wday;
            date <= ld_date;
            mon <= ld_mon;
            year <= ld_year;
        end
        else
        begin
            if (tick)
                sec <= s_n[7:0];
            if (en_min)
                min <= m_n[7:0];
            if (en_hour)
                hour <= h_n[7:0];
            if (en_day)
                wday <= w_n[7:0];
            if (en_day)
                date <= d_n[7:0];
            if (en_mon)
                mon <= mo_n[7:0];
            if (en_year)
                year <= y_n[7:0];
        end
    end

    // One-cycle pulse when the year rolls from 99 to 00.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            century <= 1'b0;
        else
            century <= en_year & y_n[8] & ~load;
    end

    AST_HOUR_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
        (en_hour && !load && hour == `RTK_MAX_HOUR) |=> hour == 8'h00)
        else $error("hours did not wrap from 23 to 0");
    AST_YEAR_ROLL: assert property (@(posedge clk_sys) disable iff (rst)
        (en_year && !load && year == `RTK_MAX_YEAR) |=> (year == 8'h00 && century))
        else $error("year roll missed or century pulse absent");
    COV_YEAR_ROLL: cover property (@(posedge clk_sys) disable iff (rst) century);
endmodule : rtk_core

// ==== logic/rtk_regs.sv ====
/*
 * Two-wire serial slave holding the user time registers, the control
 * register and the watchdog restart and reset-source flags.
 * Assumes open-drain pins resolved outside and a watchdog on clk_sys.
 */
`timescale 1ns/1ps
`include "rtk_cfg.svh"
module rtk_regs
    import rtk_pkg::*;
#(
    parameter int TICK_CYCLES = `RTK_TICK_PERIOD_NS / `RTK_CLK_PERIOD_NS
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] dev_sel,
    input wire logic low_supply_rst,
    input wire logic low_backup,
    input wire logic watchdog_timeout,
    output logic watchdog_restart
);
    localparam int TW = $clog2(TICK_CYCLES);
    logic [5:0] sync1_r, sync2_r;
    logic scl_s, sda_s, scl_p_r, sda_p_r, lowsup_s, lb_s;
    logic [1:0] sel_s;
    logic start, stop, rise, fall;
    logic [TW-1:0] div_r;
    logic tick_r;
    rtk_state_e st_r;
    logic [3:0] cnt_r;
    rtk_byte_t sh_r, tx_r, ptr_r, rd_data;
    logic ack_drv_r, ack_seen_r;
    logic r_bit_r, w_bit_r, cf_r, wto_r, lowsup_r, lb_r;
    rtk_byte_t user_r [0:6];
    rtk_byte_t c_sec, c_min, c_hour, c_wday, c_date, c_mon, c_year;
    logic century;

    // Pins pass two flops; only the second stage is read.
    // Bus lines and selects idle high, but the supply and backup inputs idle low,
    // so that leaving reset does not raise a false reset-source flag.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync1_r <= 6'h3C;
            sync2_r <= 6'h3C;
        end
        else
        begin
            sync1_r <= {scl_in, sda_in, dev_sel, low_supply_rst, low_backup};
            sync2_r <= sync1_r;
        end
    end
    assign {scl_s, sda_s, sel_s, lowsup_s, lb_s} = sync2_r;

    // Bus conditions from the synchronised lines.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
        end
        else
        begin
            scl_p_r <= scl_s;
            sda_p_r <= sda_s;
        end
    end
    assign start = scl_s & scl_p_r & sda_p_r & ~sda_s;
    assign stop = scl_s & scl_p_r & ~sda_p_r & sda_s;
    assign rise = scl_s & ~scl_p_r;
    assign fall = ~scl_s & scl_p_r;

    // One-second enable; replaces the crystal since only one clock exists.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            div_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= (div_r == TW'(TICK_CYCLES - 1));
            div_r <= (div_r == TW'(TICK_CYCLES - 1)) ? '0 : div_r + 1'b1;
        end
    end

    // Decoded byte events and register selects.
    logic byte_end, ack_end, addr_ok, wr_fire, rd_load, in_time, w_ctrl, w_wdrf;
    logic capture, load_core;
    logic [3:0] idx;
    assign byte_end = fall & (cnt_r == 4'h7);
    assign ack_end = fall & (cnt_r == 4'h8);
    assign addr_ok = (sh_r[7:4] == `RTK_SLAVE_ID) & (sh_r[2:1] == sel_s);
    assign wr_fire = byte_end & (st_r == ST_WR);
    assign rd_load = ack_end & (st_r == ST_RD) & (ack_drv_r | ack_seen_r);
    assign in_time = (ptr_r >= `RTK_REG_SEC) & (ptr_r <= `RTK_REG_YEAR);
    assign idx = ptr_r[3:0] - 4'h2;
    assign w_ctrl = wr_fire & (ptr_r == `RTK_REG_CTRL);
    assign w_wdrf = wr_fire & (ptr_r == `RTK_REG_WDRF);
    assign capture = w_ctrl & sh_r[`RTK_CTRL_RD_BIT] & ~r_bit_r & ~w_bit_r;
    assign load_core = w_ctrl & ~sh_r[`RTK_CTRL_WR_BIT] & w_bit_r;

    // Read mux; unmapped offsets and reserved bits read as zero.
    assign rd_data = (ptr_r == `RTK_REG_CTRL) ? {1'b0, cf_r, 4'h0, w_bit_r, r_bit_r}
                   : in_time ? user_r[idx[2:0]]
                   : (ptr_r == `RTK_REG_WDRF) ? {wto_r, lowsup_r, lb_r, 5'h00}
                   : 8'h00;

    // Serial slave: address, pointer, write bytes, read bytes.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'hFF;
            ptr_r <= 8'h00;
            ack_drv_r <= 1'b0;
            ack_seen_r <= 1'b0;
        end
        else if (start)
        begin
            st_r <= ST_DEV;
            cnt_r <= 4'hF; // The clock fall that ends a start carries no bit.
            ack_drv_r <= 1'b0;
            tx_r <= 8'hFF;
        end
        else if (stop)
        begin
            st_r <= ST_IDLE;
            ack_drv_r <= 1'b0;
            tx_r <= 8'hFF;
        end
        else if (st_r != ST_IDLE)
        begin
            if (rise && cnt_r != 4'h8)
                sh_r <= {sh_r[6:0], sda_s};
            if (rise && cnt_r == 4'h8)
                ack_seen_r <= ~sda_s;
            if (fall && cnt_r == 4'hF)
                cnt_r <= 4'h0;
            if (fall && cnt_r < 4'h7)
            begin
                cnt_r <= cnt_r + 4'h1;
                tx_r <= {tx_r[6:0], 1'b1};
            end
            if (byte_end)
            begin
                cnt_r <= 4'h8;
                tx_r <= 8'hFF;
                ack_drv_r <= (st_r != ST_RD) & ((st_r != ST_DEV) | addr_ok);
                if (st_r == ST_DEV)
                    st_r <= !addr_ok ? ST_IDLE : sh_r[0] ? ST_RD : ST_PTR;
                else if (st_r == ST_PTR)
                begin
                    ptr_r <= sh_r;
                    st_r <= ST_WR;
                end
                else if (st_r == ST_WR)
                    ptr_r <= ptr_r + 8'h01;
            end
            if (ack_end)
            begin
                cnt_r <= 4'h0;
                ack_drv_r <= 1'b0;
                ack_seen_r <= 1'b0;
                if (rd_load)
                begin
                    tx_r <= rd_data;
                    ptr_r <= ptr_r + 8'h01;
                end
                else if (st_r == ST_RD)
                    st_r <= ST_IDLE;
            end
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = ack_drv_r | ((st_r == ST_RD) & (cnt_r != 4'h8) & ~tx_r[7]);

    // User registers: host writes are masked, a capture copies the counters.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 7; i++)
                user_r[i] <= (i >= 3 && i <= 5) ? `RTK_RST_ONE : `RTK_RST_ZERO;
        end
        else if (capture)
        begin
            user_r[0] <= c_sec;
            user_r[1] <= c_min;
            user_r[2] <= c_hour;
            user_r[3] <= c_wday;
            user_r[4] <= c_date;
            user_r[5] <= c_mon;
            user_r[6] <= c_year;
        end
        else if (wr_fire && in_time)
        begin
            case (ptr_r)
                `RTK_REG_SEC: user_r[0] <= sh_r & `RTK_MASK_SEC;
                `RTK_REG_MIN: user_r[1] <= sh_r & `RTK_MASK_MIN;
                `RTK_REG_HOUR: user_r[2] <= sh_r & `RTK_MASK_HOUR;
                `RTK_REG_WDAY: user_r[3] <= sh_r & `RTK_MASK_WDAY;
                `RTK_REG_DATE: user_r[4] <= sh_r & `RTK_MASK_DATE;
                `RTK_REG_MON: user_r[5] <= sh_r & `RTK_MASK_MON;
                default: user_r[6] <= sh_r & `RTK_MASK_YEAR;
            endcase
        end
    end

    // Control and flag bits; every hardware set wins over a clear.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            r_bit_r <= 1'b0;
            w_bit_r <= 1'b0;
            cf_r <= 1'b0;
            wto_r <= 1'b0;
            lowsup_r <= 1'b0;
            lb_r <= 1'b0;
            watchdog_restart <= 1'b0;
        end
        else
        begin
            if (w_ctrl)
            begin
                r_bit_r <= sh_r[`RTK_CTRL_RD_BIT];
                w_bit_r <= sh_r[`RTK_CTRL_WR_BIT];
            end
            cf_r <= century | (cf_r & ~(rd_load && ptr_r == `RTK_REG_CTRL));
            wto_r <= watchdog_timeout | (w_wdrf ? sh_r[`RTK_WDRF_WTO_BIT] : wto_r);
            lowsup_r <= lowsup_s | (w_wdrf ? sh_r[`RTK_WDRF_LOWSUP_BIT] : lowsup_r);
            lb_r <= lb_s | (w_wdrf ? sh_r[`RTK_WDRF_LB_BIT] : lb_r);
            watchdog_restart <= w_wdrf & (sh_r[3:0] == `RTK_WDRF_KEY);
        end
    end

    rtk_core u_core (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick_r & ~w_bit_r),
        .load(load_core),
        .ld_sec(user_r[0]),
        .ld_min(user_r[1]),
        .ld_hour(user_r[2]),
        .ld_wday(user_r[3]),
        .ld_date(user_r[4]),
        .ld_mon(user_r[5]),
        .ld_year(user_r[6]),
        .sec(c_sec),
        .min(c_min),
        .hour(c_hour),
        .wday(c_wday),
        .date(c_date),
        .mon(c_mon),
        .year(c_year),
        .century(century)
    );

    AST_WDRF_LAYOUT: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_load && ptr_r == `RTK_REG_WDRF) |=> (tx_r[4:0] == 5'h00 && tx_r[7] == $past(wto_r)))
        else $error("restart register read layout wrong");
    AST_LOWSUP_SET: assert property (@(posedge clk_sys) disable iff (rst)
        lowsup_s |=> (lowsup_r && wto_r == ($past(watchdog_timeout)
        | ($past(w_wdrf) ? $past(sh_r[7]) : $past(wto_r)))))
        else $error("low-supply flag not set or watchdog flag disturbed");
    AST_KEY_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
        w_wdrf |=> (watchdog_restart == ($past(sh_r[3:0]) == 4'hA)) ##1 !watchdog_restart)
        else $error("watchdog restart pulse wrong for key");
    AST_YEAR_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_fire && ptr_r == `RTK_REG_YEAR && !capture) |=> user_r[6] == $past(sh_r))
        else $error("year write not stored");
    AST_MON_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        user_r[5][7:5] == 3'h0)
        else $error("month upper bits not zero");
    AST_DATE_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        user_r[4][7:6] == 2'h0 && user_r[2][7:6] == 2'h0)
        else $error("date or hour upper bits not zero");
    AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (rst)
        capture |=> (user_r[0] == $past(c_sec) && user_r[6] == $past(c_year)))
        else $error("capture did not copy counters");
    AST_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
        load_core |=> (c_sec == $past(user_r[0]) && c_mon == $past(user_r[5])))
        else $error("clearing freeze did not load counters");
    AST_CF_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_load && ptr_r == `RTK_REG_CTRL && !century) |=> !cf_r)
        else $error("century flag not cleared by read");
    COV_WRITE: cover property (@(posedge clk_sys) disable iff (rst) wr_fire);
    COV_READ: cover property (@(posedge clk_sys) disable iff (rst) rd_load);
    COV_RESTART: cover property (@(posedge clk_sys) disable iff (rst) watchdog_restart);
endmodule : rtk_regs

// ==== verif/rtk_host.sv ====
/*
 * Behavioural host processor that masters the two-wire bus.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/1ps
module rtk_host
    import rtk_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // Each clock phase lasts well above the delay of the slave's two-flop synchroniser.
    localparam int HALF = 8;

    // The bus idles with data released, so the pull-up holds it high, and the clock is driven high.
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wait_q(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_q

    // Works as a repeated start too, since it first releases data with clock low.
    task automatic start_cond();
        sda_pull = 1'b0;
        wait_q(HALF);
        scl = 1'b1;
        wait_q(HALF);
        sda_pull = 1'b1;
        wait_q(HALF);
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_q(2);
        sda_pull = 1'b1;
        wait_q(HALF);
        scl = 1'b1;
        wait_q(HALF);
        sda_pull = 1'b0;
        wait_q(HALF);
    endtask : stop_cond

    // Data moves two cycles after the clock falls, so it is never seen as a start or stop.
    task automatic clk_bit(input logic b, output logic s);
        wait_q(2);
        sda_pull = !b;
        wait_q(HALF);
        scl = 1'b1;
        wait_q(HALF);
        s = sda_line;
        scl = 1'b0;
    endtask : clk_bit

    task automatic put_byte(input rtk_byte_t b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask : put_byte

    task automatic get_byte(input logic ack, output rtk_byte_t b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        clk_bit(!ack, s);
    endtask : get_byte
endmodule : rtk_host

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench for the timekeeping register slave.
 * Assumes rtk_host masters the bus and the design's own assertions run inside it.
 */
`timescale 1ns/1ps
`include "rtk_cfg.svh"
module tb_top
    import rtk_pkg::*;
;
    // A short tick keeps rollovers within a few transactions.
    localparam int TICKS = 100;
    logic clk_sys;
    logic rst;
    logic scl;
    logic sda_pull;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    logic [1:0] dev_sel;
    logic low_supply_rst;
    logic low_backup;
    logic watchdog_timeout;
    logic watchdog_restart;
    int miscompares;
    int samples_checked;
    int restarts;
    logic ack;
    rtk_byte_t s1;
    rtk_byte_t wq[$];
    rtk_byte_t rq[$];
    rtk_byte_t ex[$];

    // Open-drain data line with a pull-up: high unless someone pulls it low.
    assign sda_line = !sda_pull && !(sda_oe && !sda_out);

    rtk_host host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

    rtk_regs #(.TICK_CYCLES(TICKS)) dut (
        .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .dev_sel(dev_sel), .low_supply_rst(low_supply_rst),
        .low_backup(low_backup), .watchdog_timeout(watchdog_timeout),
        .watchdog_restart(watchdog_restart));

    initial clk_sys = 1'b0;
    always #12.5 clk_sys = ~clk_sys;

    // Restart pulses are counted so that flag-only writes can be told apart.
    always @(posedge clk_sys)
        if (watchdog_restart === 1'b1)
            restarts++;

    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    task automatic compare(input rtk_byte_t seen, input rtk_byte_t exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : compare

    task automatic send(input rtk_byte_t b);
        host.put_byte(b, ack);
        compare({7'h00, ack}, 8'h01, "ack");
    endtask : send

    // Writes the queued bytes from the given pointer onwards, then empties the queue.
    task automatic wr(input rtk_byte_t ptr);
        host.start_cond();
        send({`RTK_SLAVE_ID, 1'b0, dev_sel, 1'b0});
        send(ptr);
        foreach (wq[i])
            send(wq[i]);
        host.stop_cond();
        wq.delete();
    endtask : wr

    // Sets the pointer by a short write, then reads n bytes, refusing the last.
    task automatic rd(input rtk_byte_t ptr, input int n);
        rtk_byte_t b;
        rq.delete();
        wr(ptr);
        host.start_cond();
        send({`RTK_SLAVE_ID, 1'b0, dev_sel, 1'b1});
        for (int i = 0; i < n; i++)
        begin
            host.get_byte(i < n - 1, b);
            rq.push_back(b);
        end
        host.stop_cond();
    endtask : rd

    // A hang anywhere is cut short here and counted as a mismatch.
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        miscompares++;
        final_report();
    end

    // Main sequence.
    initial
    begin
        rst = 1'b1;
        dev_sel = 2'b10;
        low_supply_rst = 1'b0;
        low_backup = 1'b0;
        watchdog_timeout = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        // A wrong select code must not be acknowledged.
        host.start_cond();
        host.put_byte({`RTK_SLAVE_ID, 1'b0, ~dev_sel, 1'b0}, ack);
        compare({7'h00, ack}, 8'h00, "foreign select");
        host.stop_cond();
        rd(8'h0B, 1);
        compare(rq[0], 8'h00, "unmapped read");
        // Frozen user registers take writes; unused high bits read as zero.
        wq = '{8'h02};
        wr(`RTK_REG_CTRL);
        wq = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
        wr(`RTK_REG_HOUR);
        rd(`RTK_REG_HOUR, 4);
        compare(rq[0], 8'h3F, "hour mask");
        compare(rq[1], 8'h07, "weekday mask");
        compare(rq[2], 8'h3F, "date mask");
        compare(rq[3], 8'h1F, "month mask");
        // One second before a new century, read back while still frozen.
        ex = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
        wq = ex;
        wr(`RTK_REG_SEC);
        rd(`RTK_REG_SEC, 7);
        foreach (rq[i])
            compare(rq[i], ex[i], "frozen write");
        compare(rq[2], 8'h23, "hour held");
        compare(rq[6], 8'h99, "year held");
        // Thaw loads the counters, then a capture shows every field rolled over.
        wq = '{8'h00};
        wr(`RTK_REG_CTRL);
        wq = '{8'h01};
        wr(`RTK_REG_CTRL);
        rd(`RTK_REG_SEC, 7);
        s1 = rq[0];
        compare((s1 >= 8'h01 && s1 <= 8'h07) ? 8'h01 : 8'h00, 8'h01, "seconds");
        compare(rq[1], 8'h00, "minutes");
        compare(rq[2], 8'h00, "hours");
        compare(rq[3], 8'h01, "weekday");
        compare(rq[4], 8'h01, "date");
        compare(rq[5], 8'h01, "month");
        compare(rq[6], 8'h00, "year");
        // The overflow flag shows once and is gone on the next read.
        rd(`RTK_REG_CTRL, 1);
        compare(rq[0], 8'h41, "century set");
        rd(`RTK_REG_CTRL, 1);
        compare(rq[0], 8'h01, "century cleared");
        // Writing 1 over 1 is no rising edge, so the snapshot must not move.
        repeat (300) @(negedge clk_sys);
        wq = '{8'h01};
        wr(`RTK_REG_CTRL);
        rd(`RTK_REG_SEC, 1);
        compare(rq[0], s1, "no recapture");
        wq = '{8'h00};
        wr(`RTK_REG_CTRL);
        wq = '{8'h01};
        wr(`RTK_REG_CTRL);
        // Close to a minute passes, so minutes are read too in case seconds came round.
        rd(`RTK_REG_SEC, 2);
        compare((rq[0] !== s1 || rq[1] !== 8'h00) ? 8'h01 : 8'h00, 8'h01, "recapture");
        // Both reset sources and low backup leave their flags together.
        watchdog_timeout = 1'b1;
        low_supply_rst = 1'b1;
        low_backup = 1'b1;
        repeat (6) @(negedge clk_sys);
        watchdog_timeout = 1'b0;
        low_supply_rst = 1'b0;
        low_backup = 1'b0;
        repeat (6) @(negedge clk_sys);
        rd(`RTK_REG_WDRF, 1);
        compare(rq[0], 8'hE0, "flags set");
        // A non-key write clears flags without a restart; the key restarts.
        wq = '{8'h00};
        wr(`RTK_REG_WDRF);
        rd(`RTK_REG_WDRF, 1);
        compare(rq[0], 8'h00, "flags cleared");
        compare(8'(restarts), 8'h00, "no restart");
        wq = '{8'h3A};
        wr(`RTK_REG_WDRF);
        rd(`RTK_REG_WDRF, 1);
        compare(rq[0], 8'h20, "flag write");
        compare(8'(restarts), 8'h01, "restart");
        final_report();
    end
endmodule : tb_top
